// file: rtl/gdp_port_config.sv
// Serial-bus slave holding drive strength and pull resistor registers,
// with the pad stage it steers.
// Assumes bus lines and pin inputs are synchronous to sys_clk_i and
// that SCL stays well below a quarter of the system clock rate.
`timescale 1ns/1ps
`default_nettype none

module gdp_port_config
    import gdp_pkg::*;
#(
    parameter int PINS = 16,
    parameter logic [6:0] DEV_ADDR = `GDP_DEV_ADDR
)
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [PINS-1:0] dir_in_i,
    input wire logic [PINS-1:0] out_data_i,
    output logic [PINS-1:0] pad_o,
    output logic [PINS-1:0] pad_oe_o,
    output logic [4*PINS-1:0] finger_en_o,
    output logic [PINS-1:0] pull_up_en_o,
    output logic [PINS-1:0] pull_dn_en_o,
    output logic busy_o
);
    // Maps a command code to {valid, slot}
    function automatic logic [3:0] map_cmd(input logic [7:0] cmd);
        logic [3:0] r;
        r = 4'h0;
        unique case (cmd)
            `GDP_CMD_DRIVE_0: r = {1'h1, 3'h0};
            `GDP_CMD_DRIVE_1: r = {1'h1, 3'h1};
            `GDP_CMD_DRIVE_2: r = {1'h1, 3'h2};
            `GDP_CMD_DRIVE_3: r = {1'h1, 3'h3};
            `GDP_CMD_PULL_EN_LO: r = {1'h1, 3'h4};
            `GDP_CMD_PULL_EN_HI: r = {1'h1, 3'h5};
            `GDP_CMD_PULL_SEL_LO: r = {1'h1, 3'h6};
            `GDP_CMD_PULL_SEL_HI: r = {1'h1, 3'h7};
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // Bus events from the detector
    logic start_p;
    logic stop_p;
    logic rise_p;
    logic fall_p;
    logic sda_s;

    // Sequencer state and byte bookkeeping
    gdp_state_e state;
    logic [2:0] bit_cnt;
    logic [6:0] rx_sh;
    logic [7:0] tx_sh;
    logic rw_read;
    logic ack_seen;
    logic sda_low;
    // Command pointer, flips within a pair
    logic [7:0] cmd_q;
    // Register storage, addressed by slot
    logic [7:0] regs [0:7];

    // Decoded helpers
    logic rx_state;
    logic got_byte;
    logic [7:0] rx_byte;
    logic [3:0] map_q;
    logic [7:0] rd_byte;
    logic ack_state;

    gdp_bus_cond u_cond (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .start_o(start_p),
        .stop_o(stop_p),
        .scl_rise_o(rise_p),
        .scl_fall_o(fall_p),
        .sda_o(sda_s)
    );

    // Byte capture on the eighth rising clock
    assign rx_state = (state == GDP_ADDR) || (state == GDP_CMD) || (state == GDP_WDATA);
    assign got_byte = rx_state & rise_p & (bit_cnt == 3'h7);
    assign rx_byte = {rx_sh, sda_s};
    assign ack_state = (state == GDP_ADDR_ACK) || (state == GDP_CMD_ACK)
        || (state == GDP_WDATA_ACK);
    // Unmapped codes read as zero
    assign map_q = map_cmd(cmd_q);
    assign rd_byte = map_q[3] ? regs[map_q[2:0]] : 8'h00;

    // Open-drain data line: only ever pulls low
    assign sda_o = 1'h0;
    assign sda_oe_o = sda_low;
    assign busy_o = (state != GDP_IDLE);

    // Sequencer transitions
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= GDP_IDLE;
            rw_read <= 1'h0;
            ack_seen <= 1'h0;
        end
        else if (start_p)
        begin
            // Start or repeated start
            state <= GDP_ADDR;
            ack_seen <= 1'h0;
        end
        else if (stop_p)
        begin
            state <= GDP_IDLE;
            ack_seen <= 1'h0;
        end
        else
        begin
            unique case (state)
                GDP_IDLE: state <= GDP_IDLE;
                GDP_ADDR:
                begin
                    if (got_byte)
                    begin
                        // Foreign address: stay off the bus
                        if (rx_byte[7:1] == DEV_ADDR)
                        begin
                            state <= GDP_ADDR_ACK;
                            rw_read <= rx_byte[0];
                        end
                        else
                        begin
                            state <= GDP_IDLE;
                        end
                    end
                end
                GDP_CMD: state <= got_byte ? GDP_CMD_ACK : GDP_CMD;
                GDP_WDATA: state <= got_byte ? GDP_WDATA_ACK : GDP_WDATA;
                GDP_ADDR_ACK:
                begin
                    // Second falling edge ends the acknowledge
                    if (fall_p && sda_low)
                    begin
                        state <= rw_read ? GDP_RDATA : GDP_CMD;
                    end
                end
                GDP_CMD_ACK:
                begin
                    if (fall_p && sda_low)
                    begin
                        state <= GDP_WDATA;
                    end
                end
                GDP_WDATA_ACK:
                begin
                    if (fall_p && sda_low)
                    begin
                        state <= GDP_WDATA;
                    end
                end
                GDP_RDATA:
                begin
                    if (rise_p && (bit_cnt == 3'h7))
                    begin
                        state <= GDP_MACK;
                        ack_seen <= 1'h0;
                    end
                end
                GDP_MACK:
                begin
                    // Not-acknowledge ends the read; wait for stop
                    if (rise_p && sda_s)
                    begin
                        state <= GDP_IDLE;
                    end
                    else if (rise_p)
                    begin
                        ack_seen <= 1'h1;
                    end
                    else if (fall_p && ack_seen)
                    begin
                        state <= GDP_RDATA;
                        ack_seen <= 1'h0;
                    end
                end
            endcase
        end
    end

    // Bit counter and receive shifter
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            bit_cnt <= 3'h0;
            rx_sh <= 7'h00;
        end
        else if (start_p || stop_p)
        begin
            bit_cnt <= 3'h0;
        end
        else if (rise_p && (rx_state || state == GDP_RDATA))
        begin
            // Three bits wrap to zero after each byte
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh <= rx_byte[6:0];
        end
    end

    // Data line drive and transmit shifter
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sda_low <= 1'h0;
            tx_sh <= 8'h00;
        end
        else if (start_p || stop_p)
        begin
            sda_low <= 1'h0;
        end
        else if (fall_p)
        begin
            unique case (state)
                GDP_ADDR_ACK:
                begin
                    // Leaving a read acknowledge drives the first bit
                    if (sda_low && rw_read)
                    begin
                        sda_low <= ~rd_byte[7];
                        tx_sh <= {rd_byte[6:0], 1'h0};
                    end
                    else
                    begin
                        sda_low <= ~sda_low;
                    end
                end
                GDP_CMD_ACK,
                GDP_WDATA_ACK: sda_low <= ~sda_low;
                GDP_RDATA:
                begin
                    sda_low <= ~tx_sh[7];
                    tx_sh <= {tx_sh[6:0], 1'h0};
                end
                GDP_MACK:
                begin
                    // Master acked: next byte of the pair goes out
                    if (ack_seen)
                    begin
                        sda_low <= ~rd_byte[7];
                        tx_sh <= {rd_byte[6:0], 1'h0};
                    end
                    else
                    begin
                        sda_low <= 1'h0;
                    end
                end
                default: sda_low <= 1'h0;
            endcase
        end
    end

    // Command pointer
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cmd_q <= 8'h00;
        end
        else if (got_byte && state == GDP_CMD)
        begin
            cmd_q <= rx_byte;
        end
        else if ((got_byte && state == GDP_WDATA)
            || (rise_p && state == GDP_RDATA && bit_cnt == 3'h7))
        begin
            cmd_q <= cmd_q ^ `GDP_PAIR_FLIP;
        end
    end

    // Register storage; writes land on the eighth bit
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < 4; i++)
            begin
                regs[i] <= `GDP_RST_DRIVE;
            end
            regs[`GDP_IDX_PULL_EN_LO] <= `GDP_RST_PULL_EN;
            regs[`GDP_IDX_PULL_EN_LO + 3'h1] <= `GDP_RST_PULL_EN;
            regs[`GDP_IDX_PULL_SEL_LO] <= `GDP_RST_PULL_SEL;
            regs[`GDP_IDX_PULL_SEL_LO + 3'h1] <= `GDP_RST_PULL_SEL;
        end
        else if (got_byte && state == GDP_WDATA && map_q[3])
        begin
            regs[map_q[2:0]] <= rx_byte;
        end
    end

    // Pad stage fed from the stored fields
    gdp_pad_stage #(
        .PINS(PINS)
    ) u_pad (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .dir_in_i(dir_in_i),
        .out_data_i(out_data_i),
        .drive_code_i({regs[3], regs[2], regs[1], regs[0]}),
        .pull_enable_i({regs[5], regs[4]}),
        .pull_select_i({regs[7], regs[6]}),
        .pad_o(pad_o),
        .pad_oe_o(pad_oe_o),
        .finger_en_o(finger_en_o),
        .pull_up_en_o(pull_up_en_o),
        .pull_dn_en_o(pull_dn_en_o)
    );
endmodule
`default_nettype wire

// file: pkg/gdp_consts.svh
// Command codes, reset values and finger masks for the port configuration slice.
// Assumes inclusion by bare name from the package and the bench.
`ifndef GDP_CONSTS_SVH
`define GDP_CONSTS_SVH

// Drive strength bytes, four pins per byte, two bits per pin
`define GDP_CMD_DRIVE_0 8'h40
`define GDP_CMD_DRIVE_1 8'h41
`define GDP_CMD_DRIVE_2 8'h42
`define GDP_CMD_DRIVE_3 8'h43
// Pull resistor enable and selection pairs
`define GDP_CMD_PULL_EN_LO 8'h46
`define GDP_CMD_PULL_EN_HI 8'h47
`define GDP_CMD_PULL_SEL_LO 8'h48
`define GDP_CMD_PULL_SEL_HI 8'h49

// Storage slots behind the command codes
`define GDP_IDX_DRIVE_0 3'h0
`define GDP_IDX_PULL_EN_LO 3'h4
`define GDP_IDX_PULL_SEL_LO 3'h6

// Reset values: full drive, resistors off, pull-up selected
`define GDP_RST_DRIVE 8'hFF
`define GDP_RST_PULL_EN 8'h00
`define GDP_RST_PULL_SEL 8'hFF

// Pair partner is found by flipping the low command bit
`define GDP_PAIR_FLIP 8'h01
// Slave address used when none is given
`define GDP_DEV_ADDR 7'h20
// Finger masks per drive strength code
`define GDP_FINGERS_00 4'h0
`define GDP_FINGERS_01 4'h1
`define GDP_FINGERS_10 4'h3
`define GDP_FINGERS_11 4'hF

`endif

// file: pkg/gdp_pkg.sv
// Types shared by the port configuration slice.
// Assumes the constants header sits on the include path.
package gdp_pkg;
    `include "gdp_consts.svh"

    // Serial slave sequencer states; nine of them, so three bits cannot hold them
    typedef enum logic [3:0] {
        GDP_IDLE,
        GDP_ADDR,
        GDP_ADDR_ACK,
        GDP_CMD,
        GDP_CMD_ACK,
        GDP_WDATA,
        GDP_WDATA_ACK,
        GDP_RDATA,
        GDP_MACK
    } gdp_state_e;

    // Storage slot index
    typedef logic [2:0] gdp_idx_t;
endpackage

// file: rtl/gdp_bus_cond.sv
// Edge and condition detector for the two serial bus lines.
// Assumes the lines are already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module gdp_bus_cond
    import gdp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic start_o,
    output logic stop_o,
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic sda_o
);
    // Previous samples, idle-high like the bus
    logic scl_q;
    logic sda_q;

    // Keep one cycle of history on both lines
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Start: data falls while clock stays high
    assign start_o = scl_q & scl_i & sda_q & ~sda_i;
    assign stop_o = scl_q & scl_i & ~sda_q & sda_i;
    assign scl_rise_o = ~scl_q & scl_i;
    assign scl_fall_o = scl_q & ~scl_i;
    assign sda_o = sda_i;
endmodule
`default_nettype wire

// file: rtl/gdp_pad_stage.sv
// Output stage model: direction, data, finger enables and pull resistors.
// Assumes configuration words arrive already decoded per pin.
`timescale 1ns/1ps
`default_nettype none
module gdp_pad_stage
    import gdp_pkg::*;
#(
    parameter int PINS = 16
)
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [PINS-1:0] dir_in_i,
    input wire logic [PINS-1:0] out_data_i,
    input wire logic [2*PINS-1:0] drive_code_i,
    input wire logic [PINS-1:0] pull_enable_i,
    input wire logic [PINS-1:0] pull_select_i,
    output logic [PINS-1:0] pad_o,
    output logic [PINS-1:0] pad_oe_o,
    output logic [4*PINS-1:0] finger_en_o,
    output logic [PINS-1:0] pull_up_en_o,
    output logic [PINS-1:0] pull_dn_en_o
);
    // Code to finger mask; 10 gives half of full strength
    function automatic logic [3:0] finger_mask(input logic [1:0] code);
        logic [3:0] m;
        m = `GDP_FINGERS_00;
        unique case (code)
            2'h0: m = `GDP_FINGERS_00;
            2'h1: m = `GDP_FINGERS_01;
            2'h2: m = `GDP_FINGERS_10;
            2'h3: m = `GDP_FINGERS_11;
        endcase
        return m;
    endfunction

    // Registered pad controls, so no glitch reaches the pins
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pad_o <= '0;
            pad_oe_o <= '0;
            finger_en_o <= '0;
            pull_up_en_o <= '0;
            pull_dn_en_o <= '0;
        end
        else
        begin
            for (int p = 0; p < PINS; p++)
            begin
                pad_o[p] <= out_data_i[p];
                pad_oe_o[p] <= ~dir_in_i[p];
                finger_en_o[4*p +: 4] <= dir_in_i[p] ? 4'h0
                    : finger_mask(drive_code_i[2*p +: 2]);
                pull_up_en_o[p] <= dir_in_i[p] & pull_enable_i[p] & pull_select_i[p];
                pull_dn_en_o[p] <= dir_in_i[p] & pull_enable_i[p] & ~pull_select_i[p];
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/gdp_port_config_monitor.sv
// Checker for the port configuration slice, attached by bind.
// Assumes it sees only the top module ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gdp_port_config_monitor
    import gdp_pkg::*;
#(
    parameter int PINS = 16
)
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [PINS-1:0] dir_in_i,
    input wire logic [PINS-1:0] out_data_i,
    input wire logic [PINS-1:0] pad_o,
    input wire logic [PINS-1:0] pad_oe_o,
    input wire logic [4*PINS-1:0] finger_en_o,
    input wire logic [PINS-1:0] pull_up_en_o,
    input wire logic [PINS-1:0] pull_dn_en_o,
    input wire logic busy_o
);
    // Per pin: any finger on
    logic [PINS-1:0] fing_any;
    // Some nibble is not one of the four legal masks
    logic fing_bad;

    // Reduce the finger word per pin
    always_comb
    begin
        fing_bad = 1'b0;
        for (int p = 0; p < PINS; p++)
        begin
            fing_any[p] = |finger_en_o[4*p +: 4];
            if (!(finger_en_o[4*p +: 4] inside {4'h0, 4'h1, 4'h3, 4'hF}))
            begin
                fing_bad = 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // First edge after release skipped: stage still holds reset zeros
    a_pad_data_follow: assert property ($past(reset_n_i) |->
        pad_o == $past(out_data_i) && pad_oe_o == ~$past(dir_in_i))
        else $error("pad does not follow data or direction");
    a_finger_input_off: assert property ($past(reset_n_i) |->
        (fing_any & $past(dir_in_i)) == '0)
        else $error("fingers on for an input pin");
    a_finger_code_ok: assert property (!fing_bad)
        else $error("finger mask not a legal level");
    a_pull_one_way: assert property ((pull_up_en_o & pull_dn_en_o) == '0)
        else $error("pull-up and pull-down both on");
    a_pull_inputs_only: assert property ($past(reset_n_i) |->
        ((pull_up_en_o | pull_dn_en_o) & ~$past(dir_in_i)) == '0)
        else $error("pull resistor on an output pin");
    a_stop_goes_idle: assert property (
        (scl_i && $past(scl_i) && sda_i && !$past(sda_i)) |-> ##[1:3] (!busy_o && !sda_oe_o))
        else $error("stop did not return to idle");
    // Pulling data low with clock high would fake a start condition
    a_drive_clock_low: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("data pulled low while clock high");
    a_idle_no_pull: assert property ((!busy_o && !$past(busy_o)) |-> !sda_oe_o)
        else $error("idle sequencer holds data low");
    a_open_drain_data: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    a_reset_defaults: assert property ($rose(reset_n_i) |->
        pull_up_en_o == '0 && pull_dn_en_o == '0 && !sda_oe_o && !busy_o)
        else $error("outputs not at defaults after reset");
endmodule
`default_nettype wire

// file: verification/gdp_i2c_master.sv
// Behavioural serial bus master facing the slice.
// Assumes an open-drain data line with a pull-up, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module gdp_i2c_master
(
    input wire logic sys_clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    // System clocks per clock phase, twice the slice minimum
    localparam int PHASE = 4;

    // Bus idles high on both lines
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic wait_phase();
        repeat (PHASE) @(negedge sys_clk_i);
    endtask

    // One clock pulse; returns the resolved line at the high phase
    task automatic put_bit(input logic b, output logic got);
        sda_o = b;
        wait_phase();
        scl_o = 1'b1;
        wait_phase();
        got = sda_line_i;
        scl_o = 1'b0;
    endtask

    // Start, also used as repeated start
    task automatic start_cond();
        sda_o = 1'b1;
        wait_phase();
        scl_o = 1'b1;
        wait_phase();
        sda_o = 1'b0;
        wait_phase();
        scl_o = 1'b0;
    endtask

    task automatic stop_cond();
        sda_o = 1'b0;
        wait_phase();
        scl_o = 1'b1;
        wait_phase();
        sda_o = 1'b1;
        wait_phase();
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(b[i], g);
        end
        put_bit(1'b1, g);
        ack = (g === 1'b0);
    endtask

    // Last byte is not acknowledged
    task automatic recv_byte(output logic [7:0] b, input logic last);
        logic g;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, b[i]);
        end
        put_bit(last, g);
    endtask

    task automatic clocks(input int n);
        logic g;
        repeat (n) put_bit(1'b1, g);
    endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the port configuration slice.
// Assumes the master model, the checker and the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "gdp_consts.svh"
module tb_top;
    import gdp_pkg::*;
    localparam int PINS = 16;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic scl;
    logic m_sda;
    logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic [PINS-1:0] dir_in = 16'hFFFF;
    logic [PINS-1:0] out_data = 16'hA55A;
    logic [PINS-1:0] pad;
    logic [PINS-1:0] pad_oe;
    logic [4*PINS-1:0] finger;
    logic [PINS-1:0] pu;
    logic [PINS-1:0] pd;
    logic busy;
    logic ack;
    int bad_count = 0;
    int checks_done = 0;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    // Pulled-up wire: low if either side pulls
    assign sda_line = m_sda & (sda_oe ? sda_o : 1'b1);

    gdp_i2c_master u_mst (.sys_clk_i(sys_clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(m_sda));

    gdp_port_config #(.PINS(PINS)) u_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .dir_in_i(dir_in), .out_data_i(out_data),
        .pad_o(pad), .pad_oe_o(pad_oe), .finger_en_o(finger), .pull_up_en_o(pu),
        .pull_dn_en_o(pd), .busy_o(busy));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic send(input logic [7:0] b);
        logic a;
        u_mst.send_byte(b, a);
        check(64'(a), 64'h1);
    endtask

    // Two bytes to a register pair
    task automatic wr_pair(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        u_mst.start_cond();
        send({`GDP_DEV_ADDR, 1'b0});
        send(cmd);
        send(d0);
        send(d1);
        u_mst.stop_cond();
    endtask

    // Point, restart, read two bytes; expected first byte high
    task automatic rd_pair(input logic [7:0] cmd, input logic [15:0] exp);
        logic [7:0] b0;
        logic [7:0] b1;
        u_mst.start_cond();
        send({`GDP_DEV_ADDR, 1'b0});
        send(cmd);
        u_mst.start_cond();
        send({`GDP_DEV_ADDR, 1'b1});
        u_mst.recv_byte(b0, 1'b0);
        u_mst.recv_byte(b1, 1'b1);
        u_mst.stop_cond();
        check(64'({b0, b1}), 64'(exp));
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(64'({pu, pd}), 64'h0);
        rd_pair(8'h46, 16'h0000);
        rd_pair(8'h48, 16'hFFFF);
        rd_pair(8'h40, 16'hFFFF);
        wr_pair(8'h46, 8'hA5, 8'h3C);
        wr_pair(8'h48, 8'h0F, 8'hF0);
        rd_pair(8'h47, 16'h3CA5);
        rd_pair(8'h49, 16'hF00F);
        check(64'(pu), 64'h3005);
        check(64'(pd), 64'h0CA0);
        // All pins to outputs: pulls must drop
        dir_in = 16'h0000;
        repeat (2) @(negedge sys_clk);
        check(64'({pu, pd}), 64'h0);
        wr_pair(8'h40, 8'hE4, 8'h00);
        check(finger, 64'hFFFFFFFF0000F310);
        check(64'({pad, pad_oe}), 64'hA55AFFFF);
        // Abort after the command byte
        u_mst.start_cond();
        send({`GDP_DEV_ADDR, 1'b0});
        send(8'h46);
        u_mst.stop_cond();
        check(64'({busy, sda_oe}), 64'h0);
        // Read 8'hA5, stall after its first bit with data held low
        u_mst.start_cond();
        send({`GDP_DEV_ADDR, 1'b1});
        u_mst.clocks(1);
        repeat (2) @(negedge sys_clk);
        check(64'(sda_oe), 64'h1);
        u_mst.clocks(9);
        check(64'({busy, sda_oe}), 64'h0);
        u_mst.clocks(3);
        check(64'({busy, sda_oe}), 64'h0);
        u_mst.stop_cond();
        // Foreign address: no acknowledge, sequencer stays off the bus
        u_mst.start_cond();
        u_mst.send_byte({`GDP_DEV_ADDR ^ 7'h01, 1'b0}, ack);
        check(64'({ack, busy, sda_oe}), 64'h0);
        u_mst.stop_cond();
        // Unmapped command is acknowledged and reads as zero
        rd_pair(8'h50, 16'h0000);
        // Reset pin mid-run
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(64'({busy, sda_oe}), 64'h0);
        reset_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(finger, 64'hFFFFFFFFFFFFFFFF);
        rd_pair(8'h46, 16'h0000);
        test_done();
    end

    // Watchdog well past the expected few thousand cycles
    initial
    begin
        repeat (50000) @(posedge sys_clk);
        bad_count++;
        test_done();
    end
endmodule

bind gdp_port_config gdp_port_config_monitor #(.PINS(PINS)) u_mon (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .dir_in_i(dir_in_i), .out_data_i(out_data_i),
    .pad_o(pad_o), .pad_oe_o(pad_oe_o), .finger_en_o(finger_en_o),
    .pull_up_en_o(pull_up_en_o), .pull_dn_en_o(pull_dn_en_o), .busy_o(busy_o));
`default_nettype wire
